// >>> shared/wdc_pkg.sv
// Purpose: constants for the watchpoint debug control block
// Assumes: registers are reached only through the 38-bit scan register
// Notes: Function list below, one line per behaviour
// Function
// - size code 00 byte, 01 half, 10 word
// - unit 1 linked match feeds unit 0 chain
// - linked match latch: addr/ctl enables, data stored
// - latch cleared on control value write or tap reset
// - unit 1 span match feeds unit 0 range
// - unit 1 has own external condition input, output
// - halt request only when enable bit set
// - control value bits 0 to 7 have mask bits, enable bit 8 none
// - 16-bit fetch compares only valid half
// - debug control 3 bits, rw bit selects
// - bit2 irq disable, bit1 request, bit0 ack
// - bit1 synchronised, ORed with external request
// - request latch opens only in run-test-idle
// - acknowledge out is core ack OR bit0
// - interrupt enable low while bit2 set
// - interrupt enable low while acknowledge high
// - mask bit 1 always matches that position
// - 38-bit scan: data, address, rw; update-dr
// - control value bit positions 0 to 8
package wdc_pkg;
  // scan register layout
  localparam int SCAN_W = 38;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  localparam int SCAN_ADDR_LSB = 32;
  localparam int SCAN_RW_BIT = 37;
  // register map: upper two address bits pick the group
  localparam logic [4:0] REG_DEBUG_CONTROL = 5'h00;
  localparam logic [1:0] GRP_UNIT0 = 2'h1;
  localparam logic [1:0] GRP_UNIT1 = 2'h2;
  localparam logic [2:0] IDX_ADDR_VAL = 3'h0;
  localparam logic [2:0] IDX_ADDR_MSK = 3'h1;
  localparam logic [2:0] IDX_DATA_VAL = 3'h2;
  localparam logic [2:0] IDX_DATA_MSK = 3'h3;
  localparam logic [2:0] IDX_CTL_VAL = 3'h4;
  localparam logic [2:0] IDX_CTL_MSK = 3'h5;
  // control value / mask layout
  localparam int CTL_VAL_W = 9;
  localparam int CTL_MSK_W = 8;
  localparam int CB_WNR = 0;
  localparam int CB_SIZE_LSB = 1;
  localparam int CB_OPC_N = 3;
  localparam int CB_TRANS_N = 4;
  localparam int CB_EXT = 5;
  localparam int CB_CHAIN = 6;
  localparam int CB_RANGE = 7;
  localparam int CB_ENABLE = 8;
  // transfer size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_RSVD = 2'h3;
  // debug control layout and reset
  localparam int DC_W = 3;
  localparam int DC_IRQ_OFF = 2;
  localparam int DC_REQ = 1;
  localparam int DC_ACK = 0;
  localparam logic [2:0] DEBUG_CONTROL_RST = 3'h0;
  // reset values of watchpoint registers
  localparam logic [31:0] WP_WORD_RST = 32'h00000000;
  localparam logic [8:0] WP_CTL_RST = 9'h000;
  // synchroniser width for tap side inputs
  localparam int TAP_SYNC_W = 8;
endpackage : wdc_pkg

// >>> verilog/wdc_sync2.sv
// Purpose: two flip-flop level synchroniser
// Assumes: inputs are levels from another clock domain
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module wdc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // next values: plain shift through two stages
  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // registers, cleared asynchronously
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule : wdc_sync2
`default_nettype wire

// >>> verilog/wdc_watch_unit.sv
// Purpose: one masked watchpoint comparator with its register set
// Assumes: bus inputs are on clk_in, registers written from the scan side
// Notes: chain and range inputs come from the neighbouring unit
`timescale 1ns/1ps
`default_nettype none
module wdc_watch_unit (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [2:0] idx_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] rdata_out,
  input wire logic bus_valid_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic [31:0] bus_data_in,
  input wire logic half_fetch_in,
  input wire logic write_not_read_in,
  input wire logic [1:0] transfer_size_in,
  input wire logic opcode_fetch_n_in,
  input wire logic translate_n_in,
  input wire logic ext_cond_in,
  input wire logic chain_in,
  input wire logic range_in,
  input wire logic link_clear_in,
  output logic halt_out,
  output logic span_match_out,
  output logic linked_match_out
);
  logic [31:0] addr_val_r, addr_msk_r, data_val_r, data_msk_r;
  logic [8:0] ctl_val_r;
  logic [7:0] ctl_msk_r;
  logic [31:0] addr_val_nxt, addr_msk_nxt, data_val_nxt, data_msk_nxt;
  logic [8:0] ctl_val_nxt;
  logic [7:0] ctl_msk_nxt;
  logic link_r;
  logic link_nxt;
  logic [7:0] ctl_bus;
  logic [15:0] half_word;
  logic [31:0] data_eff;
  logic size_ok, ac_ok, dc_ok;

  // control bus in value-register order
  assign ctl_bus = {range_in, chain_in, ext_cond_in, translate_n_in,
                    opcode_fetch_n_in, transfer_size_in, write_not_read_in};
  // a 16-bit fetch only drives one half; replicate it on both halves
  assign half_word = bus_addr_in[1] ? bus_data_in[31:16] : bus_data_in[15:0];
  assign data_eff = half_fetch_in ? {half_word, half_word} : bus_data_in;
  // reserved size code never matches unless the size field is masked
  assign size_ok = (transfer_size_in != wdc_pkg::SIZE_RSVD) | (&ctl_msk_r[2:1]);
  // xnor compare, mask bit 1 forces that position to match
  assign ac_ok = (&(~(addr_val_r ^ bus_addr_in) | addr_msk_r))
               & (&(~(ctl_val_r[4:0] ^ ctl_bus[4:0]) | ctl_msk_r[4:0]))
               & size_ok;
  assign dc_ok = (&(~(data_val_r ^ data_eff) | data_msk_r))
               & (&(~(ctl_val_r[7:5] ^ ctl_bus[7:5]) | ctl_msk_r[7:5]));
  // all three fields on the same bus cycle
  assign span_match_out = bus_valid_in & ac_ok & dc_ok;
  assign halt_out = span_match_out & ctl_val_r[wdc_pkg::CB_ENABLE];
  assign linked_match_out = link_r;

  // register writes and chain latch
  always_comb
  begin
    addr_val_nxt = addr_val_r;
    addr_msk_nxt = addr_msk_r;
    data_val_nxt = data_val_r;
    data_msk_nxt = data_msk_r;
    ctl_val_nxt = ctl_val_r;
    ctl_msk_nxt = ctl_msk_r;
    link_nxt = link_r;
    if (bus_valid_in && ac_ok)
      link_nxt = dc_ok;
    if (wr_en_in)
    begin
      case (idx_in)
        wdc_pkg::IDX_ADDR_VAL: addr_val_nxt = wdata_in;
        wdc_pkg::IDX_ADDR_MSK: addr_msk_nxt = wdata_in;
        wdc_pkg::IDX_DATA_VAL: data_val_nxt = wdata_in;
        wdc_pkg::IDX_DATA_MSK: data_msk_nxt = wdata_in;
        wdc_pkg::IDX_CTL_VAL:
        begin
          ctl_val_nxt = wdata_in[8:0];
          link_nxt = 1'b0;
        end
        wdc_pkg::IDX_CTL_MSK: ctl_msk_nxt = wdata_in[7:0];
        default: ;
      endcase
    end
    if (link_clear_in)
      link_nxt = 1'b0;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      addr_val_r <= wdc_pkg::WP_WORD_RST;
      addr_msk_r <= wdc_pkg::WP_WORD_RST;
      data_val_r <= wdc_pkg::WP_WORD_RST;
      data_msk_r <= wdc_pkg::WP_WORD_RST;
      ctl_val_r <= wdc_pkg::WP_CTL_RST;
      ctl_msk_r <= wdc_pkg::WP_CTL_RST[7:0];
      link_r <= 1'b0;
    end
    else
    begin
      addr_val_r <= addr_val_nxt;
      addr_msk_r <= addr_msk_nxt;
      data_val_r <= data_val_nxt;
      data_msk_r <= data_msk_nxt;
      ctl_val_r <= ctl_val_nxt;
      ctl_msk_r <= ctl_msk_nxt;
      link_r <= link_nxt;
    end
  end

  // read mux, unused indices read zero
  always_comb
  begin
    case (idx_in)
      wdc_pkg::IDX_ADDR_VAL: rdata_out = addr_val_r;
      wdc_pkg::IDX_ADDR_MSK: rdata_out = addr_msk_r;
      wdc_pkg::IDX_DATA_VAL: rdata_out = data_val_r;
      wdc_pkg::IDX_DATA_MSK: rdata_out = data_msk_r;
      wdc_pkg::IDX_CTL_VAL: rdata_out = {23'h000000, ctl_val_r};
      wdc_pkg::IDX_CTL_MSK: rdata_out = {24'h000000, ctl_msk_r};
      default: rdata_out = 32'h00000000;
    endcase
  end
endmodule : wdc_watch_unit
`default_nettype wire

// >>> verilog/wdc_top.sv
// Purpose: watchpoint debug control beside a processor core
// Assumes: tap pins arrive from another clock and are synchronised here
// Notes: the tap clock is sampled; edges are found on clk_in
`timescale 1ns/1ps
`default_nettype none
module wdc_top (
  input wire logic clk_in,
  input wire logic rst_in,
  // test access side
  input wire logic tap_clock_in,
  input wire logic tap_reset_n_in,
  input wire logic tdi_in,
  input wire logic capture_dr_in,
  input wire logic shift_dr_in,
  input wire logic update_dr_in,
  input wire logic run_test_idle_in,
  output logic tdo_out,
  // core bus side
  input wire logic bus_valid_in,
  input wire logic [31:0] core_addr_in,
  input wire logic [31:0] core_data_in,
  input wire logic half_fetch_in,
  input wire logic write_not_read_in,
  input wire logic [1:0] transfer_size_in,
  input wire logic opcode_fetch_n_in,
  input wire logic translate_n_in,
  input wire logic external_condition_unit0_in,
  input wire logic external_condition_unit1_in,
  // debug handshake
  input wire logic debug_request_in,
  input wire logic core_debug_acknowledge_in,
  output logic breakpoint_out,
  output logic debug_request_out,
  output logic debug_request_combined_out,
  output logic debug_acknowledge_out,
  output logic core_interrupt_enable_out,
  output logic user_mode_n_out,
  output logic linked_match_out,
  output logic span_match_out
);
  // synchronised tap side levels
  logic [7:0] tap_raw;
  logic [7:0] tap_s;
  logic tck_s, tdi_s, cap_s, shf_s, upd_s, rti_s, trst_n_s, ext_req_s;

  // scan state
  logic [37:0] scan_r;
  logic [37:0] scan_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic tck_d_r;
  logic tck_d_nxt;
  logic upd_d_r;
  logic upd_d_nxt;
  logic tdo_r;
  logic tdo_nxt;
  logic tck_rise, tck_fall, upd_rise;

  // decoded register access
  logic acc_wr, acc_rd;
  logic [4:0] acc_addr;
  logic [31:0] acc_data;
  logic wr_u0, wr_u1;
  logic [31:0] rd_u0, rd_u1;

  // debug control state
  logic [2:0] dctl_r;
  logic [2:0] dctl_nxt;
  logic req_hold_r;
  logic req_hold_nxt;

  // core side outputs
  logic halt0, halt1, span0, span1, link0, link1;
  logic bkpt_r;
  logic bkpt_nxt;
  logic user_r;
  logic user_nxt;
  logic ack_comb;

  // every tap input passes two flops before any logic reads it
  assign tap_raw = {debug_request_in, tap_reset_n_in, run_test_idle_in, update_dr_in,
                    shift_dr_in, capture_dr_in, tdi_in, tap_clock_in};

  wdc_sync2 #(
    .W(wdc_pkg::TAP_SYNC_W)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(tap_raw),
    .sync_out(tap_s)
  );

  assign tck_s = tap_s[0];
  assign tdi_s = tap_s[1];
  assign cap_s = tap_s[2];
  assign shf_s = tap_s[3];
  assign upd_s = tap_s[4];
  assign rti_s = tap_s[5];
  assign trst_n_s = tap_s[6];
  assign ext_req_s = tap_s[7];

  // edge finders on the sampled tap clock and update state
  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;
  assign upd_rise = upd_s & ~upd_d_r;

  // the access fires once, on entry to update-dr
  assign acc_addr = scan_r[wdc_pkg::SCAN_RW_BIT-1:wdc_pkg::SCAN_ADDR_LSB];
  assign acc_data = scan_r[wdc_pkg::DATA_W-1:0];
  assign acc_wr = upd_rise & scan_r[wdc_pkg::SCAN_RW_BIT];
  assign acc_rd = upd_rise & ~scan_r[wdc_pkg::SCAN_RW_BIT];
  assign wr_u0 = acc_wr & (acc_addr[4:3] == wdc_pkg::GRP_UNIT0);
  assign wr_u1 = acc_wr & (acc_addr[4:3] == wdc_pkg::GRP_UNIT1);

  // scan shifter: capture loads last read result, shift is lsb first
  always_comb
  begin
    scan_nxt = scan_r;
    tdo_nxt = tdo_r;
    tck_d_nxt = tck_s;
    upd_d_nxt = upd_s;
    if (tck_rise && cap_s)
      scan_nxt[wdc_pkg::DATA_W-1:0] = rdata_r;
    else if (tck_rise && shf_s)
      scan_nxt = {tdi_s, scan_r[37:1]};
    // tdo changes on the falling edge so the debugger samples it stable
    if (tck_fall)
      tdo_nxt = scan_r[0];
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      scan_r <= 38'h0000000000;
      tdo_r <= 1'b0;
      tck_d_r <= 1'b0;
      upd_d_r <= 1'b0;
    end
    else
    begin
      scan_r <= scan_nxt;
      tdo_r <= tdo_nxt;
      tck_d_r <= tck_d_nxt;
      upd_d_r <= upd_d_nxt;
    end
  end

  // read path: result is held until the next capture shifts it out
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (acc_rd)
    begin
      case (acc_addr[4:3])
        wdc_pkg::GRP_UNIT0: rdata_nxt = rd_u0;
        wdc_pkg::GRP_UNIT1: rdata_nxt = rd_u1;
        default:
        begin
          if (acc_addr == wdc_pkg::REG_DEBUG_CONTROL)
            rdata_nxt = {29'h00000000, dctl_r};
          else
            rdata_nxt = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_r <= 32'h00000000;
    else
      rdata_r <= rdata_nxt;
  end

  // debug control register and the request hold latch
  always_comb
  begin
    dctl_nxt = dctl_r;
    req_hold_nxt = req_hold_r;
    if (acc_wr && (acc_addr == wdc_pkg::REG_DEBUG_CONTROL))
      dctl_nxt = acc_data[wdc_pkg::DC_W-1:0];
    // held closed outside run-test-idle so several cores can be armed
    // and released together
    if (rti_s)
      req_hold_nxt = dctl_r[wdc_pkg::DC_REQ];
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dctl_r <= wdc_pkg::DEBUG_CONTROL_RST;
      req_hold_r <= 1'b0;
    end
    else
    begin
      dctl_r <= dctl_nxt;
      req_hold_r <= req_hold_nxt;
    end
  end

  // request, acknowledge and interrupt enable towards the core
  assign debug_request_out = req_hold_r | ext_req_s;
  assign debug_request_combined_out = req_hold_r | ext_req_s;
  assign ack_comb = core_debug_acknowledge_in | dctl_r[wdc_pkg::DC_ACK];
  assign debug_acknowledge_out = ack_comb;
  // interrupts only when neither acknowledge nor disable is active
  assign core_interrupt_enable_out = ~ack_comb & ~dctl_r[wdc_pkg::DC_IRQ_OFF];

  // watchpoint 1: own external condition, no upstream neighbour
  wdc_watch_unit u_unit1 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_en_in(wr_u1),
    .idx_in(acc_addr[2:0]),
    .wdata_in(acc_data),
    .rdata_out(rd_u1),
    .bus_valid_in(bus_valid_in),
    .bus_addr_in(core_addr_in),
    .bus_data_in(core_data_in),
    .half_fetch_in(half_fetch_in),
    .write_not_read_in(write_not_read_in),
    .transfer_size_in(transfer_size_in),
    .opcode_fetch_n_in(opcode_fetch_n_in),
    .translate_n_in(translate_n_in),
    .ext_cond_in(external_condition_unit1_in),
    .chain_in(1'b0),
    .range_in(1'b0),
    .link_clear_in(~trst_n_s),
    .halt_out(halt1),
    .span_match_out(span1),
    .linked_match_out(link1)
  );

  // watchpoint 0: chained and ranged off watchpoint 1
  wdc_watch_unit u_unit0 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_en_in(wr_u0),
    .idx_in(acc_addr[2:0]),
    .wdata_in(acc_data),
    .rdata_out(rd_u0),
    .bus_valid_in(bus_valid_in),
    .bus_addr_in(core_addr_in),
    .bus_data_in(core_data_in),
    .half_fetch_in(half_fetch_in),
    .write_not_read_in(write_not_read_in),
    .transfer_size_in(transfer_size_in),
    .opcode_fetch_n_in(opcode_fetch_n_in),
    .translate_n_in(translate_n_in),
    .ext_cond_in(external_condition_unit0_in),
    .chain_in(link1),
    .range_in(span1),
    .link_clear_in(~trst_n_s),
    .halt_out(halt0),
    .span_match_out(span0),
    .linked_match_out(link0)
  );

  // halt request and user mode output registered for clean edges;
  // writing watchpoints while the core runs can still glitch this, which
  // is why programming is done while the core bus is idle
  always_comb
  begin
    bkpt_nxt = halt0 | halt1;
    user_nxt = external_condition_unit1_in;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bkpt_r <= 1'b0;
      user_r <= 1'b0;
    end
    else
    begin
      bkpt_r <= bkpt_nxt;
      user_r <= user_nxt;
    end
  end

  assign breakpoint_out = bkpt_r;
  assign user_mode_n_out = user_r;
  assign linked_match_out = link1;
  assign span_match_out = span1;
  assign tdo_out = tdo_r;
endmodule : wdc_top
`default_nettype wire

// >>> verification/wdc_debugger_model.sv
// Purpose: debugger side of the scan port, shifts one 38-bit access per call
// Assumes: tap pins change on clk_in rising edges; tap period is 8 clk cycles
// Notes: tap clock stands low between frames; tdo is read late in the low phase
`timescale 1ns/1ps
`default_nettype none
module wdc_debugger_model (
  input wire logic clk_in,
  input wire logic tdo_in,
  output logic tap_clock_out,
  output logic tdi_out,
  output logic capture_dr_out,
  output logic shift_dr_out,
  output logic update_dr_out
);
  // idle levels at time zero
  initial
  begin
    tap_clock_out = 1'b0;
    tdi_out = 1'b0;
    capture_dr_out = 1'b0;
    shift_dr_out = 1'b0;
    update_dr_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  // one tap period, low phase first so tdo has settled before it is read
  task automatic pulse(output logic b);
    tick(4);
    b = tdo_in;
    tap_clock_out <= 1'b1;
    tick(4);
    tap_clock_out <= 1'b0;
  endtask : pulse

  // capture, shift lsb first, update; q is the word captured at the start
  task automatic scan(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    logic [37:0] s;
    logic b;
    s = {wr, a, d};
    tick(1);
    capture_dr_out <= 1'b1;
    pulse(b);
    capture_dr_out <= 1'b0;
    shift_dr_out <= 1'b1;
    for (int i = 0; i < 38; i++)
    begin
      tdi_out <= s[i];
      pulse(b);
      if (i < 32)
        q[i] = b;
    end
    shift_dr_out <= 1'b0;
    tdi_out <= ~s[37]; // released line must not keep the last bit
    tick(4);
    update_dr_out <= 1'b1;
    tick(4);
    update_dr_out <= 1'b0;
    tick(4);
  endtask : scan
endmodule : wdc_debugger_model
`default_nettype wire

// >>> verification/wdc_properties.sv
// Purpose: port-level checks on the watchpoint debug control block
// Assumes: single clock domain clk_in, asynchronous reset rst_in
// Notes: bound to wdc_top below the module
`timescale 1ns/1ps
`default_nettype none
module wdc_properties (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tap_reset_n_in,
  input wire logic run_test_idle_in,
  input wire logic bus_valid_in,
  input wire logic external_condition_unit1_in,
  input wire logic debug_request_in,
  input wire logic core_debug_acknowledge_in,
  input wire logic breakpoint_out,
  input wire logic debug_request_out,
  input wire logic debug_request_combined_out,
  input wire logic debug_acknowledge_out,
  input wire logic core_interrupt_enable_out,
  input wire logic user_mode_n_out,
  input wire logic linked_match_out,
  input wire logic span_match_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;

  // cycles since the request latch could open or the pin asked; saturates
  always_comb
  begin
    quiet_nxt = quiet_r;
    if (run_test_idle_in || debug_request_in)
      quiet_nxt = 4'h0;
    else if (quiet_r != 4'hF)
      quiet_nxt = quiet_r + 4'h1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      quiet_r <= 4'hF;
    else
      quiet_r <= quiet_nxt;
  end

  a_ack_core: assert property (core_debug_acknowledge_in |-> debug_acknowledge_out)
    else $error("acknowledge out low while core acknowledges");
  a_ie_ack: assert property (debug_acknowledge_out |-> !core_interrupt_enable_out)
    else $error("interrupt enable high during acknowledge");
  a_req_ext: assert property (debug_request_in [*3] |-> debug_request_out)
    else $error("external request not passed on");
  a_req_pair: assert property (debug_request_out == debug_request_combined_out)
    else $error("request outputs differ");
  a_req_rti: assert property ($rose(debug_request_out) |-> quiet_r < 4'h8)
    else $error("request rose without run-test-idle or pin");
  a_user_copy: assert property (!$past(rst_in) |-> user_mode_n_out == $past(external_condition_unit1_in))
    else $error("user mode output does not follow unit 1 condition");
  a_bkpt_bus: assert property (!bus_valid_in |=> !breakpoint_out)
    else $error("halt request without a bus cycle");
  a_span_bus: assert property (span_match_out |-> bus_valid_in)
    else $error("span match without a bus cycle");
  a_link_trst: assert property (!tap_reset_n_in [*4] |-> !linked_match_out)
    else $error("linked match survives tap reset");

  c_bkpt: cover property ($rose(breakpoint_out));
  c_link: cover property ($rose(linked_match_out));
  c_span: cover property ($rose(span_match_out));
  c_req: cover property ($rose(debug_request_out));
endmodule : wdc_properties

bind wdc_top wdc_properties u_wdc_properties (.*);
`default_nettype wire

// >>> verification/watchpoint_debug_control_test.sv
// Purpose: scan-driven tests of the watchpoint debug control block
// Assumes: debugger model shifts accesses; bench plays the core side
// Notes: watch registers are only written while the core bus is idle
`timescale 1ns/1ps
`default_nettype none
module watchpoint_debug_control_test;
  logic clk_in, tap_clock_in, tdi_in, capture_dr_in, shift_dr_in, update_dr_in, tdo_out;
  logic rst_in = 1'b1, tap_reset_n_in = 1'b1, run_test_idle_in = 1'b0, bus_valid_in = 1'b0;
  logic half_fetch_in = 1'b0, write_not_read_in = 1'b0, opcode_fetch_n_in = 1'b0, translate_n_in = 1'b1;
  logic external_condition_unit0_in = 1'b0, external_condition_unit1_in = 1'b0, debug_request_in = 1'b0;
  logic core_debug_acknowledge_in = 1'b0, breakpoint_out, debug_request_out, debug_request_combined_out;
  logic debug_acknowledge_out, core_interrupt_enable_out, user_mode_n_out, linked_match_out, span_match_out;
  logic [31:0] core_addr_in = 32'h0, core_data_in = 32'h0, q;
  logic [1:0] transfer_size_in = wdc_pkg::SIZE_WORD;
  int num_errors = 0, n_compared = 0;
  localparam logic [4:0] U0_AV = {wdc_pkg::GRP_UNIT0, wdc_pkg::IDX_ADDR_VAL};
  localparam logic [4:0] U0_CV = {wdc_pkg::GRP_UNIT0, wdc_pkg::IDX_CTL_VAL};
  localparam logic [4:0] U0_CM = {wdc_pkg::GRP_UNIT0, wdc_pkg::IDX_CTL_MSK};
  localparam logic [4:0] U1_CV = {wdc_pkg::GRP_UNIT1, wdc_pkg::IDX_CTL_VAL};

  wdc_top u_wdc_top (.*);
  wdc_debugger_model u_dbg (.clk_in(clk_in), .tdo_in(tdo_out), .tap_clock_out(tap_clock_in), .tdi_out(tdi_in),
    .capture_dr_out(capture_dr_in), .shift_dr_out(shift_dr_in), .update_dr_out(update_dr_in));

  // 10 MHz core clock
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    u_dbg.scan(1'b1, a, d, q);
  endtask : wr

  // a read result only leaves on the following capture, hence two scans
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    u_dbg.scan(1'b0, a, 32'h0, q);
    u_dbg.scan(1'b0, a, 32'h0, q);
    chk32(q, e);
  endtask : rd

  // all six registers of one unit, written while the bus is idle
  task automatic prog(input logic [1:0] g, input logic [31:0] av, am, dv, dm, cv, cm);
    logic [31:0] v [6];
    v = '{av, am, dv, dm, cv, cm};
    for (int i = 0; i < 6; i++)
      wr({g, i[2:0]}, v[i]);
  endtask : prog

  // one bus cycle; span is combinational, halt request a cycle later
  task automatic cyc(input logic [31:0] a, d, input logic bp, sp);
    @(posedge clk_in);
    bus_valid_in <= 1'b1;
    core_addr_in <= a;
    core_data_in <= d;
    #1 chk1(span_match_out, sp);
    @(posedge clk_in);
    bus_valid_in <= 1'b0;
    core_data_in <= ~d;
    #1 chk1(breakpoint_out, bp);
  endtask : cyc

  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  // hang guard well above the run length of the test
  initial
  begin
    #6000000;
    num_errors++;
    wrap_up();
  end

  initial
  begin
    tick(16);
    rst_in <= 1'b0;
    tick(4);
    #1 chk1(core_interrupt_enable_out, 1'b1);
    rd(wdc_pkg::REG_DEBUG_CONTROL, 32'h0);
    wr(5'h00, 32'h1);
    #1 chk1(debug_acknowledge_out, 1'b1);
    chk1(core_interrupt_enable_out, 1'b0);
    wr(5'h00, 32'h4);
    #1 chk1(debug_acknowledge_out, 1'b0);
    chk1(core_interrupt_enable_out, 1'b0);
    wr(5'h00, 32'h2);
    tick(8);
    #1 chk1(debug_request_out, 1'b0);
    rd(5'h00, 32'h2);
    @(posedge clk_in) run_test_idle_in <= 1'b1;
    tick(6);
    #1 chk1(debug_request_combined_out, 1'b1);
    @(posedge clk_in) run_test_idle_in <= 1'b0;
    wr(5'h00, 32'h0);
    tick(8);
    #1 chk1(debug_request_out, 1'b1);
    @(posedge clk_in) run_test_idle_in <= 1'b1;
    core_debug_acknowledge_in <= 1'b1;
    tick(6);
    #1 chk1(debug_request_out, 1'b0);
    chk1(core_interrupt_enable_out, 1'b0);
    @(posedge clk_in) run_test_idle_in <= 1'b0;
    core_debug_acknowledge_in <= 1'b0;
    debug_request_in <= 1'b1;
    tick(4);
    #1 chk1(debug_request_combined_out, 1'b1);
    @(posedge clk_in) debug_request_in <= 1'b0;
    // unit 0 as fetch breakpoint with the low two address bits masked
    prog(wdc_pkg::GRP_UNIT0, 32'h1000, 32'h3, 32'h0, 32'hFFFFFFFF, 32'h100, 32'hF7);
    cyc(32'h1003, 32'h0, 1'b1, 1'b0);
    cyc(32'h1004, 32'h0, 1'b0, 1'b0);
    @(posedge clk_in) opcode_fetch_n_in <= 1'b1;
    cyc(32'h1000, 32'h0, 1'b0, 1'b0);
    @(posedge clk_in) opcode_fetch_n_in <= 1'b0;
    rd(U0_AV, 32'h1000);
    rd(5'h1F, 32'h0);
    wr(U0_CV, 32'h0);
    cyc(32'h1000, 32'h0, 1'b0, 1'b0);
    // only the size field compared; the reserved code never matches
    wr(U0_CM, 32'hF9);
    for (int s = 0; s < 4; s++)
    begin
      wr(U0_CV, {23'h0, 1'b1, 5'h0, s[1:0], 1'b0});
      for (int b = 0; b < 4; b++)
      begin
        @(posedge clk_in) transfer_size_in <= b[1:0];
        cyc(32'h1000, 32'h0, b == s && b != 3, 1'b0);
      end
    end
    @(posedge clk_in) transfer_size_in <= wdc_pkg::SIZE_WORD;
    prog(wdc_pkg::GRP_UNIT0, 32'h0, 32'hFFFFFFFF, 32'hA55AA55A, 32'h0, 32'h100, 32'hF7);
    @(posedge clk_in) half_fetch_in <= 1'b1;
    cyc(32'h2, 32'hA55A1234, 1'b1, 1'b0);
    cyc(32'h0, 32'h1234A55A, 1'b1, 1'b0);
    cyc(32'h0, 32'hA55A1234, 1'b0, 1'b0);
    @(posedge clk_in) half_fetch_in <= 1'b0;
    cyc(32'h0, 32'hA55A1234, 1'b0, 1'b0);
    // unit 1 marks data 0xAA in the first 32 bytes, unit 0 fires in 256 bytes where unit 1 does not match
    prog(wdc_pkg::GRP_UNIT1, 32'h0, 32'h1F, 32'hAA, 32'h0, 32'h0, 32'hFF);
    prog(wdc_pkg::GRP_UNIT0, 32'h0, 32'hFF, 32'h0, 32'hFFFFFFFF, 32'h100, 32'h7F);
    cyc(32'h40, 32'h0, 1'b1, 1'b0);
    cyc(32'h10, 32'hAA, 1'b0, 1'b1);
    chk1(linked_match_out, 1'b1);
    cyc(32'h40, 32'h0, 1'b1, 1'b0);
    chk1(linked_match_out, 1'b1);
    cyc(32'h10, 32'h0, 1'b1, 1'b0);
    chk1(linked_match_out, 1'b0);
    cyc(32'h10, 32'hAA, 1'b0, 1'b1);
    wr(U1_CV, 32'h0);
    #1 chk1(linked_match_out, 1'b0);
    cyc(32'h10, 32'hAA, 1'b0, 1'b1);
    @(posedge clk_in) tap_reset_n_in <= 1'b0;
    tick(6);
    @(posedge clk_in) tap_reset_n_in <= 1'b1;
    #1 chk1(linked_match_out, 1'b0);
    // the synchronised tap reset still clears the latch for two more edges
    tick(2);
    cyc(32'h10, 32'hAA, 1'b0, 1'b1);
    // unit 0 now waits on the chain from unit 1
    wr(U0_CM, 32'hBF);
    wr(U0_CV, 32'h140);
    cyc(32'h80, 32'h0, 1'b1, 1'b0);
    wr(U1_CV, 32'h0);
    cyc(32'h80, 32'h0, 1'b0, 1'b0);
    @(posedge clk_in) external_condition_unit1_in <= 1'b1;
    tick(2);
    #1 chk1(user_mode_n_out, 1'b1);
    wrap_up();
  end
endmodule : watchpoint_debug_control_test
`default_nettype wire
